// ==== core/ifr_code_bank.sv ====
`timescale 1ns/100ps
`default_nettype none
module ifr_code_bank #(
  parameter int N     = 16,
  parameter int IDX_W = 4
) (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           we,
  input  wire logic [IDX_W-1:0]               waddr,
  input  wire logic [ifr_pkg::CODE_W-1:0]     wdata,
  input  wire logic [IDX_W-1:0]               raddr,
  output logic      [ifr_pkg::CODE_W-1:0]     rdata,
  output logic      [N*ifr_pkg::CODE_W-1:0]   codes
);
  localparam int CW = ifr_pkg::CODE_W;

  // ----------------------------------------------------------------
  // Code storage, all entries visible at once for the decoder.
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_entry
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          codes[i*CW +: CW] <= ifr_pkg::CODE_RESET;
        end else if (we && waddr == IDX_W'(i)) begin
          codes[i*CW +: CW] <= wdata;
        end
      end
    end
  endgenerate

  // Read data is registered so the bus mux sees a clean flop output.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= ifr_pkg::CODE_RESET;
    end else if (int'(raddr) < N) begin
      rdata <= codes[int'(raddr)*CW +: CW];
    end else begin
      rdata <= ifr_pkg::CODE_RESET;
    end
  end
endmodule
`default_nettype wire

// ==== core/ifr_group_decode.sv ====
`timescale 1ns/100ps
`default_nettype none
module ifr_group_decode #(
  parameter int N = 6
) (
  input  wire logic [N*ifr_pkg::CODE_W-1:0] codes,
  input  wire logic [N-1:0]                 levels,
  output logic      [ifr_pkg::FN_NUM-1:0]   hit,
  output logic      [ifr_pkg::FN_NUM-1:0]   assigned
);
  localparam int CW = ifr_pkg::CODE_W;

  // Code 0 marks an unused terminal and never raises a request.
  assign hit[0]      = 1'b0;
  assign assigned[0] = 1'b0;

  genvar f, t;
  generate
    for (f = 1; f < ifr_pkg::FN_NUM; f++) begin : g_fn
      logic [N-1:0] match;
      for (t = 0; t < N; t++) begin : g_term
        assign match[t] = (codes[t*CW +: CW] == CW'(f));
      end
      assign hit[f]      = |(match & levels);
      assign assigned[f] = |match;
    end
  endgenerate
endmodule
`default_nettype wire

// ==== core/ifr_input_router.sv ====
// How it works
// - command word bit n feeds remote terminal n
// - each remote terminal code resets to zero
// - code zero drives no request
// - code 1 releases motor current and brake
// - code 3 clears position deviation
// - code 5 stops; 26/27 inhibit one direction
// - code 8 requests alarm reset
// - code 9 requests home position preset
// - code 14 releases notice, 12 resets protection
// - code 13 honoured only with auto-clear disabled
// - code 16 level lifts tool limitation
// - code 18 selects current control mode
// - code 19 switches pulse scale
// - code 20 blocks pulse input
// - code 21 blocks overload alarm
// - code 22 applies current cap
// - code 23 speed cap, ignored in CSP
// - codes 28 to 31 pass sensor levels
// - code 96 excites motor for pulse input
// - codes 104/105 are probe trigger levels
// - shared codes are ORed over terminals
// - unassigned tool unlock reads one
// - unlock on both groups ANDs the groups
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module ifr_input_router (
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [ifr_pkg::ADDR_W-1:0]       paddr,
  input  wire logic [31:0]                      pwdata,
  output logic                                  pready,
  output logic      [31:0]                      prdata,
  output logic                                  pslverr,
  input  wire logic [ifr_pkg::NUM_DIRECT-1:0]   direct_terminal,
  output logic                                  motor_release,
  output logic                                  deviation_zeroing,
  output logic                                  stop_request,
  output logic                                  alarm_reset_request,
  output logic                                  home_preset_request,
  output logic                                  protective_mode_reset,
  output logic                                  load_latch_reset,
  output logic                                  notice_status_release,
  output logic                                  tool_unlock,
  output logic                                  current_mode_select,
  output logic                                  pulse_scale_switch,
  output logic                                  pulse_input_block,
  output logic                                  overload_alarm_block,
  output logic                                  current_cap_request,
  output logic                                  speed_cap_request,
  output logic                                  forward_inhibit,
  output logic                                  reverse_inhibit,
  output logic                                  forward_end_sensor,
  output logic                                  reverse_end_sensor,
  output logic                                  origin_sensor,
  output logic                                  slit_sensor,
  output logic                                  pulse_mode_excite,
  output logic                                  probe_one_trigger,
  output logic                                  probe_two_trigger,
  output logic      [ifr_pkg::GEN_W-1:0]        general_bits
);
  localparam int CW    = ifr_pkg::CODE_W;
  localparam int NR    = ifr_pkg::NUM_REMOTE;
  localparam int ND    = ifr_pkg::NUM_DIRECT;
  localparam int FN    = ifr_pkg::FN_NUM;
  localparam int AW    = ifr_pkg::ADDR_W;
  localparam int RIDX  = $clog2(NR);
  localparam int DIDX  = $clog2(ND);
  localparam int STATW = 25;
  logic [15:0]      cmd_word;
  logic [1:0]       cfg;
  logic [NR*CW-1:0] remote_codes;
  logic [ND*CW-1:0] direct_codes;
  logic [CW-1:0]    remote_rdata;
  logic [CW-1:0]    direct_rdata;
  logic [FN-1:0]    r_hit;
  logic [FN-1:0]    r_asg;
  logic [FN-1:0]    d_hit;
  logic [FN-1:0]    d_asg;
  logic [FN-1:0]    fn_hit;
  logic [STATW-1:0] stat_word;

  // ----------------------------------------------------------------
  // APB decode.
  // ----------------------------------------------------------------
  // Every access takes one wait state, which gives the code banks
  // time to present registered read data.
  logic          wr_fire;
  logic          rd_take;
  logic [AW-1:0] r_off;
  logic [AW-1:0] d_off;
  logic          sel_cmd;
  logic          sel_cfg;
  logic          sel_stat;
  logic          sel_gen;
  logic          sel_rem;
  logic          sel_dir;
  logic          aligned;
  logic          bad_acc;
  assign wr_fire  = psel && penable && pready && pwrite;
  assign rd_take  = psel && penable && !pready;
  assign r_off    = paddr - ifr_pkg::OFS_REMOTE;
  assign d_off    = paddr - ifr_pkg::OFS_DIRECT;
  assign aligned  = (paddr[1:0] == 2'h0);
  assign sel_cmd  = aligned && paddr == ifr_pkg::OFS_CMD;
  assign sel_cfg  = aligned && paddr == ifr_pkg::OFS_CFG;
  assign sel_stat = aligned && paddr == ifr_pkg::OFS_STAT;
  assign sel_gen  = aligned && paddr == ifr_pkg::OFS_GEN;
  assign sel_rem  = aligned && int'(r_off) < NR * 4;
  assign sel_dir  = aligned && int'(d_off) < ND * 4;
  assign bad_acc  = !(sel_cmd || sel_cfg || sel_stat || sel_gen ||
                      sel_rem || sel_dir) ||
                    (pwrite && (sel_stat || sel_gen));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (rd_take) begin
      pready  <= 1'b1;
      pslverr <= bad_acc;
      prdata  <= 32'h0000_0000;
      if (!pwrite) begin
        if (sel_cmd) begin
          prdata <= {16'h0000, cmd_word};
        end else if (sel_cfg) begin
          prdata <= {30'h0000_0000, cfg};
        end else if (sel_stat) begin
          prdata <= {7'h00, stat_word};
        end else if (sel_gen) begin
          prdata <= {16'h0000, general_bits};
        end else if (sel_rem) begin
          prdata <= {25'h000_0000, remote_rdata};
        end else if (sel_dir) begin
          prdata <= {25'h000_0000, direct_rdata};
        end
      end
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Command word and configuration.
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_word <= ifr_pkg::CMD_RESET;
    end else if (wr_fire && sel_cmd) begin
      cmd_word <= pwdata[15:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= ifr_pkg::CFG_RESET;
    end else if (wr_fire && sel_cfg) begin
      cfg <= pwdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Code banks and decoders.
  // ----------------------------------------------------------------
  ifr_code_bank #(.N(NR), .IDX_W(RIDX)) u_remote_bank (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (wr_fire && sel_rem),
    .waddr   (r_off[RIDX+1:2]),
    .wdata   (pwdata[CW-1:0]),
    .raddr   (r_off[RIDX+1:2]),
    .rdata   (remote_rdata),
    .codes   (remote_codes)
  );
  ifr_code_bank #(.N(ND), .IDX_W(DIDX)) u_direct_bank (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (wr_fire && sel_dir),
    .waddr   (d_off[DIDX+1:2]),
    .wdata   (pwdata[CW-1:0]),
    .raddr   (d_off[DIDX+1:2]),
    .rdata   (direct_rdata),
    .codes   (direct_codes)
  );
  ifr_group_decode #(.N(NR)) u_remote_dec (
    .codes    (remote_codes),
    .levels   (cmd_word),
    .hit      (r_hit),
    .assigned (r_asg)
  );
  ifr_group_decode #(.N(ND)) u_direct_dec (
    .codes    (direct_codes),
    .levels   (direct_terminal),
    .hit      (d_hit),
    .assigned (d_asg)
  );

  assign fn_hit = d_hit | r_hit;

  // ----------------------------------------------------------------
  // Function requests.
  // ----------------------------------------------------------------
  // Only the listed codes and codes 80 to 95 (general_bits) reach an output;
  // any other code is stored and read back but decodes to nothing.
  logic next_unlock;
  always_comb begin
    if (!d_asg[ifr_pkg::FN_UNLOCK] && !r_asg[ifr_pkg::FN_UNLOCK]) begin
      next_unlock = 1'b1;
    end else if (d_asg[ifr_pkg::FN_UNLOCK] && r_asg[ifr_pkg::FN_UNLOCK]) begin
      next_unlock = d_hit[ifr_pkg::FN_UNLOCK] &&
                    r_hit[ifr_pkg::FN_UNLOCK];
    end else begin
      next_unlock = fn_hit[ifr_pkg::FN_UNLOCK];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motor_release         <= 1'b0;
      deviation_zeroing     <= 1'b0;
      stop_request          <= 1'b0;
      alarm_reset_request   <= 1'b0;
      home_preset_request   <= 1'b0;
      protective_mode_reset <= 1'b0;
      notice_status_release <= 1'b0;
      load_latch_reset      <= 1'b0;
      tool_unlock           <= 1'b1;
    end else begin
      motor_release         <= fn_hit[ifr_pkg::FN_RELEASE];
      deviation_zeroing     <= fn_hit[ifr_pkg::FN_DEV_ZERO];
      stop_request          <= fn_hit[ifr_pkg::FN_STOP];
      alarm_reset_request   <= fn_hit[ifr_pkg::FN_ALARM_RESET_REQUEST];
      home_preset_request   <= fn_hit[ifr_pkg::FN_PRESET];
      protective_mode_reset <= fn_hit[ifr_pkg::FN_PROT_RST];
      notice_status_release <= fn_hit[ifr_pkg::FN_NOTICE];
      load_latch_reset      <= fn_hit[ifr_pkg::FN_LOAD_RST] &&
                               !cfg[ifr_pkg::CFG_AUTO_CLR_BIT];
      tool_unlock           <= next_unlock;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_mode_select  <= 1'b0;
      pulse_scale_switch   <= 1'b0;
      pulse_input_block    <= 1'b0;
      overload_alarm_block <= 1'b0;
      current_cap_request  <= 1'b0;
      speed_cap_request    <= 1'b0;
      forward_inhibit      <= 1'b0;
      reverse_inhibit      <= 1'b0;
    end else begin
      current_mode_select  <= fn_hit[ifr_pkg::FN_CUR_MODE];
      pulse_scale_switch   <= fn_hit[ifr_pkg::FN_SCALE];
      pulse_input_block    <= fn_hit[ifr_pkg::FN_PLS_BLOCK];
      overload_alarm_block <= fn_hit[ifr_pkg::FN_OVL_BLOCK];
      current_cap_request  <= fn_hit[ifr_pkg::FN_CUR_CAP];
      speed_cap_request    <= fn_hit[ifr_pkg::FN_SPD_CAP] &&
                              !cfg[ifr_pkg::CFG_CSP_BIT];
      forward_inhibit      <= fn_hit[ifr_pkg::FN_FW_INH];
      reverse_inhibit      <= fn_hit[ifr_pkg::FN_RV_INH];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      forward_end_sensor <= 1'b0;
      reverse_end_sensor <= 1'b0;
      origin_sensor      <= 1'b0;
      slit_sensor        <= 1'b0;
      pulse_mode_excite  <= 1'b0;
      probe_one_trigger  <= 1'b0;
      probe_two_trigger  <= 1'b0;
      general_bits       <= 16'h0000;
    end else begin
      forward_end_sensor <= fn_hit[ifr_pkg::FN_FW_END];
      reverse_end_sensor <= fn_hit[ifr_pkg::FN_RV_END];
      origin_sensor      <= fn_hit[ifr_pkg::FN_ORIGIN];
      slit_sensor        <= fn_hit[ifr_pkg::FN_SLIT];
      pulse_mode_excite  <= fn_hit[ifr_pkg::FN_EXCITE];
      probe_one_trigger  <= fn_hit[ifr_pkg::FN_PROBE1];
      probe_two_trigger  <= fn_hit[ifr_pkg::FN_PROBE2];
      general_bits       <= fn_hit[ifr_pkg::FN_GEN_FIRST +: 16];
    end
  end

  assign stat_word = {probe_two_trigger, probe_one_trigger,
                      pulse_mode_excite, slit_sensor, origin_sensor,
                      reverse_end_sensor, forward_end_sensor,
                      reverse_inhibit, forward_inhibit, speed_cap_request,
                      current_cap_request, overload_alarm_block,
                      pulse_input_block, pulse_scale_switch,
                      current_mode_select, tool_unlock, load_latch_reset,
                      notice_status_release, protective_mode_reset,
                      home_preset_request, alarm_reset_request,
                      stop_request, deviation_zeroing, motor_release,
                      1'b0};

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  property p_cmd_write;
    @(posedge pclk) disable iff (!presetn)
    wr_fire && sel_cmd |=> cmd_word == $past(pwdata[15:0]);
  endproperty
  a_cmd_write: assert property (p_cmd_write)
    else $error("command word not stored");
  property p_idle_codes;
    @(posedge pclk) disable iff (!presetn)
    remote_codes == '0 && direct_codes == '0 |=>
      !stop_request && !motor_release && tool_unlock;
  endproperty
  a_idle_codes: assert property (p_idle_codes)
    else $error("unused terminals raised a request");
  property p_release;
    @(posedge pclk) disable iff (!presetn)
    $rose(motor_release) |-> $past(fn_hit[ifr_pkg::FN_RELEASE]);
  endproperty
  a_release: assert property (p_release)
    else $error("release without its code");
  property p_load_gate;
    @(posedge pclk) disable iff (!presetn)
    load_latch_reset |-> !$past(cfg[ifr_pkg::CFG_AUTO_CLR_BIT]);
  endproperty
  a_load_gate: assert property (p_load_gate)
    else $error("load latch reset while auto-clear set");
  property p_speed_gate;
    @(posedge pclk) disable iff (!presetn)
    cfg[ifr_pkg::CFG_CSP_BIT] ##1 cfg[ifr_pkg::CFG_CSP_BIT]
      |-> !speed_cap_request;
  endproperty
  a_speed_gate: assert property (p_speed_gate)
    else $error("speed cap in CSP mode");
  property p_stop_or;
    @(posedge pclk) disable iff (!presetn)
    d_hit[ifr_pkg::FN_STOP] || r_hit[ifr_pkg::FN_STOP] |=> stop_request;
  endproperty
  a_stop_or: assert property (p_stop_or)
    else $error("stop request missed");
  property p_unlock_free;
    @(posedge pclk) disable iff (!presetn)
    !d_asg[ifr_pkg::FN_UNLOCK] && !r_asg[ifr_pkg::FN_UNLOCK]
      |=> tool_unlock;
  endproperty
  a_unlock_free: assert property (p_unlock_free)
    else $error("unassigned unlock not high");
  property p_unlock_and;
    @(posedge pclk) disable iff (!presetn)
    d_asg[ifr_pkg::FN_UNLOCK] && r_asg[ifr_pkg::FN_UNLOCK] &&
      !(d_hit[ifr_pkg::FN_UNLOCK] && r_hit[ifr_pkg::FN_UNLOCK])
      |=> !tool_unlock;
  endproperty
  a_unlock_and: assert property (p_unlock_and)
    else $error("unlock not ANDed over groups");
  property p_wait_state;
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_wait_state: assert property (p_wait_state)
    else $error("APB answer timing wrong");
  c_unlock_and: cover property (@(posedge pclk) disable iff (!presetn)
    d_asg[ifr_pkg::FN_UNLOCK] && r_asg[ifr_pkg::FN_UNLOCK] ##1 tool_unlock);
  c_stop: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(stop_request));
  c_slverr: cover property (@(posedge pclk) disable iff (!presetn)
    pready && pslverr);
endmodule
`default_nettype wire

// ==== pkg/ifr_pkg.sv ====
`default_nettype none
package ifr_pkg;
  // ----------------------------------------------------------------
  // Sizes.
  // ----------------------------------------------------------------
  localparam int CODE_W     = 7;
  localparam int FN_NUM     = 128;
  localparam int NUM_REMOTE = 16;
  localparam int NUM_DIRECT = 6;
  localparam int ADDR_W     = 12;
  localparam int GEN_W      = 16;

  // ----------------------------------------------------------------
  // Register map, byte addresses.
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CMD    = 12'h000;
  localparam logic [11:0] OFS_CFG    = 12'h004;
  localparam logic [11:0] OFS_STAT   = 12'h008;
  localparam logic [11:0] OFS_GEN    = 12'h00c;
  localparam logic [11:0] OFS_DIRECT = 12'h040;
  localparam logic [11:0] OFS_REMOTE = 12'h080;

  // ----------------------------------------------------------------
  // Field positions and reset values.
  // ----------------------------------------------------------------
  localparam int CFG_AUTO_CLR_BIT = 0;
  localparam int CFG_CSP_BIT      = 1;
  localparam logic [1:0]  CFG_RESET  = 2'h0;
  localparam logic [15:0] CMD_RESET  = 16'h0000;
  localparam logic [6:0]  CODE_RESET = 7'h00;

  // ----------------------------------------------------------------
  // Function-select codes.
  // ----------------------------------------------------------------
  localparam int FN_RELEASE   = 1;
  localparam int FN_DEV_ZERO  = 3;
  localparam int FN_STOP      = 5;
  localparam int FN_ALARM_RESET_REQUEST   = 8;
  localparam int FN_PRESET    = 9;
  localparam int FN_PROT_RST  = 12;
  localparam int FN_LOAD_RST  = 13;
  localparam int FN_NOTICE    = 14;
  localparam int FN_UNLOCK    = 16;
  localparam int FN_CUR_MODE  = 18;
  localparam int FN_SCALE     = 19;
  localparam int FN_PLS_BLOCK = 20;
  localparam int FN_OVL_BLOCK = 21;
  localparam int FN_CUR_CAP   = 22;
  localparam int FN_SPD_CAP   = 23;
  localparam int FN_FW_INH    = 26;
  localparam int FN_RV_INH    = 27;
  localparam int FN_FW_END    = 28;
  localparam int FN_RV_END    = 29;
  localparam int FN_ORIGIN    = 30;
  localparam int FN_SLIT      = 31;
  localparam int FN_GEN_FIRST = 80;
  localparam int FN_EXCITE    = 96;
  localparam int FN_PROBE1    = 104;
  localparam int FN_PROBE2    = 105;
endpackage
`default_nettype wire

// ==== verification/ifr_terminal_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module ifr_terminal_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [5:0] level_req,
  output logic      [5:0] direct_terminal
);
  // ----------------------------------------------------------------
  // Discrete terminals.
  // ----------------------------------------------------------------
  // Switch levels pass one register stage, so a change asked for by the
  // bench lands a whole cycle later and never races the sampling edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      direct_terminal <= 6'h00;
    end else begin
      direct_terminal <= level_req;
    end
  end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [5:0]  level_req;
  logic [5:0]  direct_terminal;
  logic        stop_request;
  logic        tool_unlock;
  logic [31:0] q;
  logic        e;
  int          bad_count;
  int          comparisons;
  int          cyc;
  int          fn[24] = '{1, 3, 5, 8, 9, 12, 14, 13, 16, 18, 19, 20, 21, 22,
                          23, 26, 27, 28, 29, 30, 31, 96, 104, 105};
  int          un[6] = '{0, 2, 32, 80, 95, 127};

  ifr_terminal_model u_ifr_terminal_model (.pclk(pclk), .presetn(presetn),
    .level_req(level_req), .direct_terminal(direct_terminal));
  ifr_input_router u_ifr_input_router (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .direct_terminal(direct_terminal), .motor_release(),
    .deviation_zeroing(), .stop_request(stop_request),
    .alarm_reset_request(), .home_preset_request(),
    .protective_mode_reset(), .load_latch_reset(),
    .notice_status_release(), .tool_unlock(tool_unlock),
    .current_mode_select(), .pulse_scale_switch(), .pulse_input_block(),
    .overload_alarm_block(), .current_cap_request(), .speed_cap_request(),
    .forward_inhibit(), .reverse_inhibit(), .forward_end_sensor(),
    .reverse_end_sensor(), .origin_sensor(), .slit_sensor(),
    .pulse_mode_excite(), .probe_one_trigger(), .probe_two_trigger(),
    .general_bits());

  // ----------------------------------------------------------------
  // Bus and check tasks.
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // A slave that never answers is caught by the cycle ceiling.
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] y);
    comparisons++;
    if (y !== x) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, y);
    end
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk("read", x, q);
  endtask

  task automatic settle;
    repeat (3) @(posedge pclk);
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Tests.
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    level_req = 6'h00;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk("unlock", 32'h1, {31'h0, tool_unlock});
    for (int n = 0; n < 16; n++) begin
      rdc(ifr_pkg::OFS_REMOTE + 12'(4 * n), 32'h0);
    end
    $display("test reset done");
    for (int i = 0; i < 24; i++) begin
      apb(1'b1, ifr_pkg::OFS_REMOTE, fn[i]);
      apb(1'b1, ifr_pkg::OFS_CMD, 32'h1);
      settle();
      rdc(ifr_pkg::OFS_STAT, (32'h1 << (i + 1)) | 32'h200);
      apb(1'b1, ifr_pkg::OFS_CMD, 32'h0);
      settle();
      rdc(ifr_pkg::OFS_STAT, (fn[i] == 16) ? 32'h0 : 32'h200);
    end
    $display("test codes done");
    apb(1'b1, ifr_pkg::OFS_CMD, 32'h1);
    foreach (un[k]) begin
      apb(1'b1, ifr_pkg::OFS_REMOTE, un[k]);
      settle();
      rdc(ifr_pkg::OFS_STAT, 32'h200);
      rdc(ifr_pkg::OFS_GEN, (un[k] >= 80 && un[k] <= 95) ?
          32'h1 << (un[k] - 80) : 32'h0);
    end
    apb(1'b1, ifr_pkg::OFS_CFG, 32'h1);
    apb(1'b1, ifr_pkg::OFS_REMOTE, 32'd13);
    settle();
    rdc(ifr_pkg::OFS_STAT, 32'h200);
    apb(1'b1, ifr_pkg::OFS_CFG, 32'h2);
    apb(1'b1, ifr_pkg::OFS_REMOTE, 32'd23);
    settle();
    rdc(ifr_pkg::OFS_STAT, 32'h200);
    $display("test gating done");
    apb(1'b1, ifr_pkg::OFS_REMOTE, 32'd5);
    apb(1'b1, ifr_pkg::OFS_REMOTE + 12'h03c, 32'd5);
    apb(1'b1, ifr_pkg::OFS_CMD, 32'h8000);
    settle();
    chk("stop", 32'h1, {31'h0, stop_request});
    apb(1'b1, ifr_pkg::OFS_CMD, 32'h0);
    settle();
    chk("stop", 32'h0, {31'h0, stop_request});
    apb(1'b1, ifr_pkg::OFS_REMOTE, 32'd0);
    apb(1'b1, ifr_pkg::OFS_DIRECT, 32'd16);
    settle();
    chk("unlock", 32'h0, {31'h0, tool_unlock});
    level_req <= 6'h01;
    settle();
    chk("unlock", 32'h1, {31'h0, tool_unlock});
    apb(1'b1, ifr_pkg::OFS_REMOTE + 12'h004, 32'd16);
    settle();
    chk("unlock", 32'h0, {31'h0, tool_unlock});
    apb(1'b1, ifr_pkg::OFS_CMD, 32'h2);
    settle();
    chk("unlock", 32'h1, {31'h0, tool_unlock});
    level_req <= 6'h00;
    settle();
    chk("unlock", 32'h0, {31'h0, tool_unlock});
    $display("test merge done");
    apb(1'b0, 12'h100, 32'h0);
    chk("err", 32'h1, {31'h0, e});
    chk("data", 32'h0, q);
    apb(1'b1, ifr_pkg::OFS_STAT, 32'hffff_ffff);
    chk("err", 32'h1, {31'h0, e});
    rdc(ifr_pkg::OFS_REMOTE + 12'h004, 32'd16);
    $display("test refusal done");
    conclude();
  end
endmodule
`default_nettype wire
